// ---- rtl/shp_pkg.sv ----
// Package with register codes, field positions and timing counts of the host bus port.
package shp_pkg;
    // Register selection codes.
    localparam logic [3:0] REG_STATUS0   = 4'h0;
    localparam logic [3:0] REG_RX_ERR    = 4'h1;
    localparam logic [3:0] REG_VECTOR    = 4'h2;
    localparam logic [3:0] REG_PENDING   = 4'h3;
    localparam logic [3:0] REG_DATA      = 4'h8;
    localparam logic [3:0] REG_NONE      = 4'h9;
    localparam logic [3:0] REG_STATUS10  = 4'hA;
    localparam logic [3:0] REG_ALIAS15   = 4'hB;
    localparam logic [3:0] REG_TC_LOW    = 4'hC;
    localparam logic [3:0] REG_TC_HIGH   = 4'hD;
    localparam logic [3:0] REG_ALIAS10   = 4'hE;
    localparam logic [3:0] REG_STATUS15  = 4'hF;
    // Pointer command field positions.
    localparam int PTR_LSB      = 0;
    localparam int PTR_CLR_W    = 5;
    localparam int PTR_HIGH_BIT = 3;
    // Vector modification field: bits 3..1 carry the status code on channel B.
    localparam int VEC_MOD_LSB  = 1;
    localparam logic [7:0] PTR_RESET = 8'h00;
    // Recovery time: 6 clocks plus 200 ns at 100 ns per clock.
    localparam int CLK_PERIOD_NS = 100;
    localparam int RECOV_NS      = 200;
    localparam int RECOV_CLKS    = 6;
    localparam logic [3:0] RECOV_CYCLES =
        4'(RECOV_CLKS + (RECOV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_WRITE, ST_ACK} shp_state_t;
endpackage

// ---- rtl/shp_sync.sv ----
// Two-flop synchroniser bank for asynchronous strobes.
module shp_sync
    import shp_pkg::*;
#(
    parameter int W = 4
) (
    input  wire logic         i_clk,
    input  wire logic         i_rst_n,
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_sync
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    // Each bit passes through two flops; the first is read only by the second.
    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_bit
            always_ff @(posedge i_clk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    meta_q[g] <= 1'b1;
                    sync_q[g] <= 1'b1;
                end else begin
                    meta_q[g] <= i_async[g];
                    sync_q[g] <= meta_q[g];
                end
            end
        end
    endgenerate

    assign o_sync = sync_q;
endmodule

// ---- rtl/shp_port.sv ----
// Host bus port: strobe sync, register selection, read steering, acknowledge.
module shp_port
    import shp_pkg::*;
(
    input  wire logic       I_REF_CLK,
    input  wire logic       I_RSTN,
    input  wire logic       i_MUX_MODE,
    input  wire logic       i_CE_N,
    input  wire logic       i_RD_N,
    input  wire logic       i_WR_N,
    input  wire logic       i_CHAN_A,
    input  wire logic       i_DATA_SEL,
    input  wire logic       i_ADDRESS_STROBE_N,
    input  wire logic       i_DATA_STROBE_N,
    input  wire logic       i_CHIP_SELECT_FIRST_N,
    input  wire logic       i_CHIP_SELECT_SECOND,
    input  wire logic       i_RD_NOT_WR,
    input  wire logic [7:0] i_MUX_ADDR_DATA,
    input  wire logic       i_IRQ_ACKNOWLEDGE_N,
    input  wire logic       i_CHAIN_ENABLE_IN,
    input  wire logic [7:0] i_D,
    input  wire logic       i_IRQ_PENDING,
    input  wire logic       i_VEC_ENABLE,
    input  wire logic [7:0] i_VECTOR,
    input  wire logic [2:0] i_VEC_STATUS,
    input  wire logic [7:0] i_PENDING_BITS,
    input  wire logic [7:0] i_STAT0_A,
    input  wire logic [7:0] i_STAT0_B,
    input  wire logic [7:0] i_RX_ERR_A,
    input  wire logic [7:0] i_RX_ERR_B,
    input  wire logic [7:0] i_STAT10_A,
    input  wire logic [7:0] i_STAT10_B,
    input  wire logic [7:0] i_STAT15_A,
    input  wire logic [7:0] i_STAT15_B,
    input  wire logic [15:0] i_TIME_CONST_A,
    input  wire logic [15:0] i_TIME_CONST_B,
    input  wire logic [7:0] i_RX_BUF_A,
    input  wire logic [7:0] i_RX_BUF_B,
    output logic      [7:0] o_D,
    output logic            o_D_OE,
    output logic            o_WR_STB,
    output logic      [3:0] o_WR_REG,
    output logic            o_WR_CHAN_A,
    output logic      [7:0] o_WR_DATA,
    output logic            o_RD_STB,
    output logic      [3:0] o_RD_REG,
    output logic            o_RD_CHAN_A,
    output logic            o_IN_SERVICE_SET,
    output logic            o_ACK_CLAIMED,
    output logic            o_RECOVERING
);
    logic       rst1_q, rst_n_q;
    logic [3:0] sync_o;
    logic       rd_s, wr_s, ds_s, as_s;
    logic       as_prev_q;
    logic       mux_ack_q, mux_cs_q, mux_ch_a_q;
    logic [4:0] mux_addr_q;
    logic [19:0] aph_q;
    logic [7:0] ptr_a_q, ptr_b_q;
    shp_state_t st_q, st_d;
    logic [7:0] rdata_q;
    logic       own_q;
    logic [3:0] recov_q;
    logic [7:0] wdata_q;
    logic [3:0] reg_q;
    logic       ch_a_q;

    // Reset is released through two flops so every flop leaves reset together.
    always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            rst1_q  <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst1_q  <= 1'b1;
            rst_n_q <= rst1_q;
        end
    end

    // Effective strobes are the overlap of chip enable and the raw strobe.
    wire eff_rd_n = i_RD_N | i_CE_N;
    wire eff_wr_n = i_WR_N | i_CE_N;

    // Strobes are asynchronous to the clock, so they pass a synchroniser.
    shp_sync #(.W(4)) u_sync (
        .i_clk  (I_REF_CLK),
        .i_rst_n(rst_n_q),
        .i_async({i_ADDRESS_STROBE_N, i_DATA_STROBE_N, eff_wr_n, eff_rd_n}),
        .o_sync (sync_o)
    );
    assign rd_s = ~sync_o[0];
    assign wr_s = ~sync_o[1];
    assign ds_s = ~sync_o[2];
    assign as_s = sync_o[3];

    // Bus is delayed like the strobe, so it must stay one clock past the rise.
    always_ff @(posedge I_REF_CLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            as_prev_q  <= 1'b1;
            aph_q      <= 20'hC0300;
            mux_ack_q  <= 1'b0;
            mux_cs_q   <= 1'b0;
            mux_ch_a_q <= 1'b0;
            mux_addr_q <= 5'h00;
        end else begin
            as_prev_q <= as_s;
            aph_q     <= {aph_q[9:0], i_IRQ_ACKNOWLEDGE_N,
                          i_CHIP_SELECT_FIRST_N, i_MUX_ADDR_DATA};
            if (as_s && !as_prev_q) begin
                mux_ack_q  <= ~aph_q[19];
                mux_cs_q   <= ~aph_q[18] & aph_q[19];
                mux_ch_a_q <= aph_q[10];
                mux_addr_q <= aph_q[15:11];
            end
        end
    end

    // Unified access view across both bus styles.
    wire mux_rw_ok = mux_cs_q & i_CHIP_SELECT_SECOND;
    wire acc_rd = i_MUX_MODE ? (ds_s & mux_rw_ok & i_RD_NOT_WR) : rd_s;
    wire acc_wr = i_MUX_MODE ? (ds_s & mux_rw_ok & ~i_RD_NOT_WR) : wr_s;
    wire ack_lo = i_MUX_MODE ? mux_ack_q : ~i_IRQ_ACKNOWLEDGE_N;
    wire ack_stb = i_MUX_MODE ? ds_s : rd_s;
    wire ch_a    = i_MUX_MODE ? mux_ch_a_q : i_CHAN_A;
    wire [7:0] ptr_cur = ch_a ? ptr_a_q : ptr_b_q;

    // Register selection from the latched address in multiplexed mode, else from pointer, point-high bit and data/control select.
    wire       pt_high  = ptr_cur[PTR_HIGH_BIT];
    wire [2:0] pcode    = ptr_cur[PTR_LSB +: 3];
    wire [3:0] sel_ptr  = {pt_high, pcode};
    wire       is_data  = i_DATA_SEL | (pt_high && pcode == 3'h0);
    wire [3:0] sel_reg  = i_MUX_MODE ? mux_addr_q[3:0] :
                          (is_data ? REG_DATA : sel_ptr);

    // Read aliases: low codes 4..7 fold onto 0..3; 11 reads as 15 and 14 reads as 10.
    wire [3:0] rd_reg =
        (!sel_reg[3])           ? {2'b00, sel_reg[1:0]} :
        (sel_reg == REG_ALIAS15) ? REG_STATUS15 :
        (sel_reg == REG_ALIAS10) ? REG_STATUS10 : sel_reg;

    // Vector on channel B carries interrupt status in its middle bits.
    wire [7:0] vec_mod = {i_VECTOR[7:4], i_VEC_STATUS, i_VECTOR[0]};
    wire [15:0] tc = ch_a ? i_TIME_CONST_A : i_TIME_CONST_B;
    logic [7:0] rd_mux;
    always_comb begin
        case (rd_reg)
            REG_STATUS0:  rd_mux = ch_a ? i_STAT0_A : i_STAT0_B;
            REG_RX_ERR:   rd_mux = ch_a ? i_RX_ERR_A : i_RX_ERR_B;
            REG_VECTOR:   rd_mux = ch_a ? i_VECTOR : vec_mod;
            REG_PENDING:  rd_mux = ch_a ? i_PENDING_BITS : 8'h00;
            REG_DATA:     rd_mux = ch_a ? i_RX_BUF_A : i_RX_BUF_B;
            REG_STATUS10: rd_mux = ch_a ? i_STAT10_A : i_STAT10_B;
            REG_STATUS15: rd_mux = ch_a ? i_STAT15_A : i_STAT15_B;
            REG_TC_LOW:   rd_mux = tc[7:0];
            REG_TC_HIGH:  rd_mux = tc[15:8];
            default:      rd_mux = 8'h00;
        endcase
    end

    // Claim decision at the falling strobe of an acknowledge cycle.
    wire claim = i_IRQ_PENDING & i_CHAIN_ENABLE_IN;
    wire wr_raw = i_MUX_MODE ? ~i_DATA_STROBE_N : ~eff_wr_n;
    wire [7:0] wbus = i_MUX_MODE ? i_MUX_ADDR_DATA : i_D;
    wire ptr_access = !i_MUX_MODE && !i_DATA_SEL && sel_ptr != 4'h0;

    // Access sequencer; the recovery counter blocks new accesses.
    always_comb begin
        st_d = st_q;
        case (st_q)
            ST_IDLE: begin
                if (recov_q == 4'h0) begin
                    if (ack_lo && ack_stb)      st_d = ST_ACK;
                    else if (acc_rd && !ack_lo) st_d = ST_READ;
                    else if (acc_wr && !ack_lo) st_d = ST_WRITE;
                end
            end
            ST_READ:  if (!acc_rd)  st_d = ST_IDLE;
            ST_WRITE: if (!acc_wr)  st_d = ST_IDLE;
            ST_ACK:   if (!ack_stb) st_d = ST_IDLE;
            default:  st_d = ST_IDLE;
        endcase
    end

    wire enter = (st_q == ST_IDLE) && (st_d != ST_IDLE);
    wire leave = (st_q != ST_IDLE) && (st_d == ST_IDLE);

    // Sequencer state, captured data and recovery count.
    always_ff @(posedge I_REF_CLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            st_q    <= ST_IDLE;
            rdata_q <= 8'h00;
            own_q   <= 1'b0;
            recov_q <= 4'h0;
            wdata_q <= 8'h00;
            reg_q   <= 4'h0;
            ch_a_q  <= 1'b0;
        end else begin
            st_q <= st_d;
            if (enter) begin
                ch_a_q <= ch_a;
                own_q  <= (st_d == ST_ACK) && claim;
                rdata_q <= (st_d == ST_ACK) ?
                           (ch_a ? i_VECTOR : vec_mod) : rd_mux;
                reg_q  <= (st_d == ST_WRITE) ? sel_reg : rd_reg;
            end
            if (st_q == ST_WRITE && wr_raw) begin
                wdata_q <= wbus;
            end
            if (leave) begin
                recov_q <= RECOV_CYCLES;
            end else if (recov_q != 4'h0) begin
                recov_q <= recov_q - 4'h1;
            end
        end
    end

    // Pointer registers: written at code 0, bits 4..0 cleared after a pointed access.
    always_ff @(posedge I_REF_CLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            ptr_a_q <= PTR_RESET;
            ptr_b_q <= PTR_RESET;
        end else if (leave && st_q != ST_ACK) begin
            if (ptr_access) begin
                if (ch_a_q) ptr_a_q[PTR_CLR_W-1:0] <= 5'h00;
                else        ptr_b_q[PTR_CLR_W-1:0] <= 5'h00;
            end else if (st_q == ST_WRITE && !i_MUX_MODE && !is_data) begin
                if (ch_a_q) ptr_a_q <= wdata_q;
                else        ptr_b_q <= wdata_q;
            end
        end
    end

    // Data drivers only during a read or owned acknowledge with strobe low.
    assign o_D    = rdata_q;
    assign o_D_OE = (st_q == ST_READ) ||
                    (st_q == ST_ACK && own_q && i_VEC_ENABLE);
    assign o_WR_STB    = leave && st_q == ST_WRITE;
    assign o_WR_REG    = reg_q;
    assign o_WR_CHAN_A = ch_a_q;
    assign o_WR_DATA   = wdata_q;
    assign o_RD_STB    = leave && st_q == ST_READ;
    assign o_RD_REG    = reg_q;
    assign o_RD_CHAN_A = ch_a_q;
    // In-service latch is set as the owned acknowledge ends.
    assign o_IN_SERVICE_SET = leave && st_q == ST_ACK && own_q;
    assign o_ACK_CLAIMED    = (st_q == ST_ACK) && own_q;
    assign o_RECOVERING     = recov_q != 4'h0;

    // Recovery holds for the full count after every access.
    chk_recovery_len: assert property (@(posedge I_REF_CLK)
        disable iff (!rst_n_q) leave |=> o_RECOVERING [*8] ##1 !o_RECOVERING)
        else $error("Recovery length wrong.");
    chk_no_early: assert property (@(posedge I_REF_CLK)
        disable iff (!rst_n_q) o_RECOVERING |=> st_q == ST_IDLE)
        else $error("Access started during recovery.");
    chk_drive_ack: assert property (@(posedge I_REF_CLK)
        disable iff (!rst_n_q) o_D_OE && st_q == ST_ACK |-> own_q)
        else $error("Vector driven without ownership.");
    chk_ius_set: assert property (@(posedge I_REF_CLK)
        disable iff (!rst_n_q) o_IN_SERVICE_SET |=> o_RECOVERING)
        else $error("In-service set outside cycle end.");
    chk_claim_need: assert property (@(posedge I_REF_CLK)
        disable iff (!rst_n_q)
        enter && st_d == ST_ACK && !i_IRQ_PENDING |=> !own_q)
        else $error("Claim without pending interrupt.");
    chk_chain_need: assert property (@(posedge I_REF_CLK)
        disable iff (!rst_n_q)
        enter && st_d == ST_ACK && !i_CHAIN_ENABLE_IN |=> !own_q)
        else $error("Claim with chain disabled.");
    chk_tc_low: assert property (@(posedge I_REF_CLK)
        disable iff (!rst_n_q)
        enter && st_d == ST_READ && rd_reg == REG_TC_LOW |=>
        rdata_q == $past(tc[7:0]))
        else $error("Time constant readback wrong.");
    chk_oe_read: assert property (@(posedge I_REF_CLK)
        disable iff (!rst_n_q) st_q == ST_WRITE |-> !o_D_OE)
        else $error("Driving during write.");
endmodule

// ---- dv/shp_host_model.sv ----
// Bus master model that runs plain and multiplexed cycles on the port.
module shp_host_model (
    input  wire logic       i_clk,
    input  wire logic [7:0] i_d,
    input  wire logic       i_d_oe,
    output logic            o_mux,
    output logic            o_ce_n,
    output logic            o_rd_n,
    output logic            o_wr_n,
    output logic            o_chan_a,
    output logic            o_dc,
    output logic            o_as_n,
    output logic            o_ds_n,
    output logic            o_cs1_n,
    output logic            o_cs2,
    output logic            o_rnw,
    output logic [7:0]      o_ad,
    output logic            o_ack_n,
    output logic [7:0]      o_d
);
    timeunit 1ns;
    timeprecision 1ns;

    // Idle bus with every strobe inactive.
    initial begin
        {o_mux, o_chan_a, o_dc, o_cs2, o_rnw} = 5'h00;
        {o_ce_n, o_rd_n, o_wr_n, o_as_n, o_ds_n, o_cs1_n, o_ack_n} = 7'h7F;
        o_ad = 8'hA5;
        o_d = 8'h5A;
    end

    // Strobe stays low six edges; read data is taken only while driven.
    task automatic hold(output logic [7:0] rd, output logic ok);
        rd = 8'h00;
        ok = 1'b0;
        repeat (6) begin
            @(posedge i_clk);
            if (i_d_oe === 1'b1) begin
                rd = i_d;
                ok = 1'b1;
            end
        end
    endtask

    // Eight recovery clocks plus the three-edge sync delay, with margin.
    task automatic recover();
        repeat (14) @(negedge i_clk);
    endtask

    // Plain bus cycle; selects stay put for the whole access.
    task automatic acc(input logic wr, a, dc, ack, input logic [7:0] wd,
                       output logic [7:0] rd, output logic ok);
        @(negedge i_clk);
        {o_chan_a, o_dc, o_ack_n} = {a, dc, ack};
        o_d = wd;
        {o_ce_n, o_wr_n, o_rd_n} = {1'b0, ~wr, wr};
        hold(rd, ok);
        @(negedge i_clk);
        {o_ce_n, o_wr_n, o_rd_n, o_ack_n} = 4'hF;
        o_d = ~wd;
        recover();
    endtask

    // Multiplexed read; the released lines carry the inverse address.
    task automatic mux_rd(input logic [7:0] adr, output logic [7:0] rd,
                          output logic ok);
        @(negedge i_clk);
        {o_mux, o_cs1_n, o_rnw, o_cs2, o_as_n} = 5'h16;
        o_ad = adr;
        @(negedge i_clk);
        o_as_n = 1'b1;
        @(negedge i_clk);
        o_ad = ~adr;
        o_ds_n = 1'b0;
        hold(rd, ok);
        @(negedge i_clk);
        {o_ds_n, o_cs1_n} = 2'h3;
        recover();
        o_mux = 1'b0;
    endtask
endmodule

// ---- dv/testbench.sv ----
// Self-checking bench for the host bus port.
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import shp_pkg::*;

    logic clk, rstn, chain, pend, ven, ch, ok, mx, ce, rn, wn, ca, dc;
    logic as_n, ds_n, c1, c2, rnw, ak, wca_s, oe, wstb, wca, isr;
    logic rstb, acl, rec, rca, rca_s;
    logic [2:0] vst;
    logic [3:0] code, wreg, wreg_s, rreg, rreg_s;
    logic [7:0] vec, pb, ba, bb, rd, ad, d, dq, wdat, wdat_s;
    logic [15:0] tca, tcb;
    int checks, n_fail, n_wr, n_isr, nw, ni, n_rd, n_rec, n_acl, na;

    shp_port dut (.I_REF_CLK(clk), .I_RSTN(rstn), .i_MUX_MODE(mx),
        .i_CE_N(ce), .i_RD_N(rn), .i_WR_N(wn), .i_CHAN_A(ca),
        .i_DATA_SEL(dc), .i_ADDRESS_STROBE_N(as_n), .i_DATA_STROBE_N(ds_n),
        .i_CHIP_SELECT_FIRST_N(c1), .i_CHIP_SELECT_SECOND(c2),
        .i_RD_NOT_WR(rnw), .i_MUX_ADDR_DATA(ad), .i_IRQ_ACKNOWLEDGE_N(ak),
        .i_CHAIN_ENABLE_IN(chain), .i_D(d), .i_IRQ_PENDING(pend),
        .i_VEC_ENABLE(ven), .i_VECTOR(vec), .i_VEC_STATUS(vst),
        .i_PENDING_BITS(pb), .i_STAT0_A(ba), .i_STAT0_B(bb),
        .i_RX_ERR_A(ba | 8'h01), .i_RX_ERR_B(bb | 8'h01),
        .i_STAT10_A(ba | 8'h0A), .i_STAT10_B(bb | 8'h0A),
        .i_STAT15_A(ba | 8'h0F), .i_STAT15_B(bb | 8'h0F),
        .i_TIME_CONST_A(tca), .i_TIME_CONST_B(tcb),
        .i_RX_BUF_A(ba | 8'h08), .i_RX_BUF_B(bb | 8'h08), .o_D(dq),
        .o_D_OE(oe), .o_WR_STB(wstb), .o_WR_REG(wreg), .o_WR_CHAN_A(wca),
        .o_WR_DATA(wdat), .o_RD_STB(rstb), .o_RD_REG(rreg),
        .o_RD_CHAN_A(rca), .o_IN_SERVICE_SET(isr), .o_ACK_CLAIMED(acl),
        .o_RECOVERING(rec));

    shp_host_model m (.i_clk(clk), .i_d(dq), .i_d_oe(oe), .o_mux(mx),
        .o_ce_n(ce), .o_rd_n(rn), .o_wr_n(wn), .o_chan_a(ca), .o_dc(dc),
        .o_as_n(as_n), .o_ds_n(ds_n), .o_cs1_n(c1), .o_cs2(c2),
        .o_rnw(rnw), .o_ad(ad), .o_ack_n(ak), .o_d(d));

    // Pulses are counted here so no check depends on exact pulse timing.
    always @(posedge clk) begin
        if (wstb === 1'b1) begin
            n_wr++;
            {wca_s, wreg_s, wdat_s} = {wca, wreg, wdat};
        end
        if (isr === 1'b1) begin
            n_isr++;
        end
        if (rstb === 1'b1) begin
            n_rd++;
            {rca_s, rreg_s} = {rca, rreg};
        end
        if (rec === 1'b1) begin
            n_rec++;
        end
        if (acl === 1'b1) begin
            n_acl++;
        end
    end

    // Read register that a pointer code reaches once aliases are folded.
    function automatic logic [3:0] exp_reg(input logic [3:0] c);
        logic [3:0] r;
        r = (c inside {[4'h4:4'h7]}) ? {2'b00, c[1:0]} : c;
        r = (c == 4'hB) ? 4'hF : (c == 4'hE) ? 4'hA : r;
        return r;
    endfunction

    // Expected read value of a pointer code on one channel.
    function automatic logic [7:0] exp_rd(input logic [3:0] c, input logic a);
        logic [3:0] r;
        logic [15:0] tc;
        r = exp_reg(c);
        tc = a ? tca : tcb;
        case (r)
            4'h2: return a ? vec : {vec[7:4], vst, vec[0]};
            4'h3: return a ? pb : 8'h00;
            4'h9: return 8'h00;
            4'hC: return tc[7:0];
            4'hD: return tc[15:8];
            default: return (a ? ba : bb) | {4'h0, r};
        endcase
    endfunction

    task automatic check(input string what, input logic [8:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // A hung run is cut short here and counted as a mismatch.
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        report_and_stop();
    end

    initial begin
        {rstn, chain, pend, ven, vst} = 7'h3D;
        {vec, pb, ba, bb, tca, tcb} = 64'hE42D5060A5C33C5A;
        repeat (6) @(negedge clk);
        rstn = 1'b1;
        repeat (6) @(negedge clk);
        // Every pointer code on both channels, each after a pointer write.
        for (int k = 0; k < 32; k++) begin
            {ch, code} = 5'(k);
            m.acc(1'b1, ch, 1'b0, 1'b1, {4'h0, code}, rd, ok);
            m.acc(1'b0, ch, 1'b0, 1'b1, 8'h00, rd, ok);
            check("pointer read", {ok, rd},
                  {1'b1, exp_rd(code, ch)});
            check("read reg", {4'h0, rca_s, rreg_s},
                  {4'h0, ch, exp_reg(code)});
        end
        nw = n_rec;
        ni = n_rd;
        m.acc(1'b0, 1'b1, 1'b0, 1'b1, 8'h00, rd, ok);
        check("cleared pointer", {ok, rd}, {1'b1, ba});
        check("read pulses", 9'(n_rd - ni), 9'h001);
        check("recovery", 9'(n_rec - nw), 9'(RECOV_CYCLES));
        m.acc(1'b1, 1'b1, 1'b0, 1'b1, 8'h0C, rd, ok);
        m.acc(1'b0, 1'b1, 1'b1, 1'b1, 8'h00, rd, ok);
        check("data select", {ok, rd}, {1'b1, ba | 8'h08});
        $display("test register reads done");
        nw = n_wr;
        m.acc(1'b1, 1'b0, 1'b1, 1'b1, 8'h96, rd, ok);
        check("write pulses", 9'(n_wr - nw), 9'h001);
        check("write data", {wca_s, wdat_s}, {1'b0, 8'h96});
        check("write reg", {5'h00, wreg_s}, {5'h00, REG_DATA});
        $display("test data write done");
        // Acknowledge is claimed only when pending with the chain enabled.
        for (int k = 0; k < 3; k++) begin
            chain = (k != 0);
            pend = (k != 2);
            ni = n_isr;
            na = n_acl;
            m.acc(1'b0, 1'b1, 1'b0, 1'b0, 8'h00, rd, ok);
            check("ack claim", {7'h00, ok, 1'(n_isr - ni)},
                  {7'h00, {2{k == 1}}});
            check("ack level", 9'(n_acl != na), 9'(k == 1));
            if (k == 1) begin
                check("ack vector", {1'b0, rd}, {1'b0, vec});
            end
        end
        pend = 1'b0;
        $display("test acknowledge done");
        m.mux_rd(8'h19, rd, ok);
        check("mux time const", {ok, rd}, {1'b1, tca[7:0]});
        check("mux read reg", {4'h0, rca_s, rreg_s},
              {4'h0, 1'b1, REG_TC_LOW});
        m.mux_rd(8'h04, rd, ok);
        check("mux vector", {ok, rd},
              {1'b1, exp_rd(4'h2, 1'b0)});
        $display("test multiplexed reads done");
        report_and_stop();
    end
endmodule
